// ---- include/smm_pin_if.sv ----
`timescale 1ns/1ns
`default_nettype none

// Raw pin levels in, filtered levels out
interface smm_pin_if;
    logic [1:0] raw;
    logic [1:0] stable;
    modport core (output raw, input stable);
    modport sync (input raw, output stable);
endinterface

`default_nettype wire

// ---- include/smm_pin_if_dummy_note.sv ----
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

// ---- include/smm_pkg.sv ----
package smm_pkg;

    // ********************************************************
    // Instruction second-byte opcodes (after the 0F escape)
    // ********************************************************
    localparam logic [7:0] OP_SAVE_SEG = 8'h78;
    localparam logic [7:0] OP_REST_SEG = 8'h79;
    localparam logic [7:0] OP_SAVE_LDT = 8'h7A;
    localparam logic [7:0] OP_REST_LDT = 8'h7B;
    localparam logic [7:0] OP_SAVE_TSK = 8'h7C;
    localparam logic [7:0] OP_REST_TSK = 8'h7D;
    localparam logic [7:0] OP_SW_ENTRY = 8'h38;
    localparam logic [7:0] OP_RESUME = 8'hAA;
    localparam logic [7:0] OP_RD_HPTR = 8'h36;
    localparam logic [7:0] OP_WR_HPTR = 8'h37;

    // ********************************************************
    // Segment register codes of the sreg3 field
    // ********************************************************
    localparam logic [2:0] SREG_CS = 3'h1;
    localparam logic [2:0] SREG_LAST = 3'h5;

    // ********************************************************
    // Configuration register one bit positions
    // ********************************************************
    localparam int CFG1_USE_BIT = 1;
    localparam int CFG1_REGION_EN_BIT = 7;

    // ********************************************************
    // Region size: code n gives 2^(n + REGION_SHIFT) bytes
    // ********************************************************
    localparam int REGION_SHIFT = 11;
    localparam logic [31:0] CS_LIMIT_4G = 32'hFFFFFFFF;

    // ********************************************************
    // Header pointer register layout and reset
    // ********************************************************
    localparam int HPTR_VALID_BIT = 0;
    localparam logic [31:0] HPTR_ADDR_MASK = 32'hFFFFFFFC;
    localparam logic [31:0] HPTR_RESET = 32'h00000000;

    // ********************************************************
    // Header word indices; word k sits at pointer - 4*(k+1)
    // ********************************************************
    localparam logic [3:0] HW_DEBUG = 4'h0;
    localparam logic [3:0] HW_FLAGS = 4'h1;
    localparam logic [3:0] HW_CTRL0 = 4'h2;
    localparam logic [3:0] HW_CUR_IP = 4'h3;
    localparam logic [3:0] HW_NEXT_IP = 4'h4;
    localparam logic [3:0] HW_CS_SEL = 4'h5;
    localparam logic [3:0] HW_DESC_LO = 4'h6;
    localparam logic [3:0] HW_DESC_HI = 4'h7;
    localparam logic [3:0] HW_IO_PORT = 4'h8;
    localparam logic [3:0] HW_IO_DATA = 4'h9;
    localparam logic [3:0] HW_STR_IDX = 4'hA;
    localparam logic [3:0] HW_LAST = 4'hA;

    // ********************************************************
    // Bit positions inside the selector word
    // ********************************************************
    localparam int HB_PRIV_LO = 16;
    localparam int HB_INTERNAL = 18;
    localparam int HB_HALTED = 19;
    localparam int HB_SOFTWARE = 20;
    localparam int HB_REP = 21;
    localparam int HB_IO_WRITE = 22;
    localparam int HB_CS_WRITABLE = 23;

    // ********************************************************
    // Trapped port access width codes
    // ********************************************************
    localparam logic [15:0] IO_SIZE_BYTE = 16'h0001;
    localparam logic [15:0] IO_SIZE_WORD = 16'h0003;
    localparam logic [15:0] IO_SIZE_DWORD = 16'h000F;

    // ********************************************************
    // Sequencer states
    // ********************************************************
    typedef enum logic [1:0] {
        SMM_IDLE = 2'b00,
        SMM_SAVE = 2'b01,
        SMM_REST = 2'b10
    } smm_st_t;

    // ********************************************************
    // Whole state of the sequencer
    // ********************************************************
    typedef struct packed {
        smm_st_t st;
        logic [3:0] idx;
        logic [31:0] hptr;
        logic in_mode;
        logic pend;
        logic pin_prev;
        logic sw_entry;
        logic mem_req;
        logic mem_we;
        logic [31:0] mem_addr;
        logic [31:0] mem_wdata;
        logic done;
        logic fault;
        logic [31:0] result;
        logic enter;
        logic resumed;
        logic rst_valid;
        logic [3:0] rst_idx;
        logic [31:0] rst_data;
        logic seg_go;
        logic [7:0] seg_op;
        logic [2:0] seg_reg;
    } smm_state_t;

    // ********************************************************
    // Synchroniser state
    // ********************************************************
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] stable;
    } smm_sync_t;

endpackage

// ---- rtl/smm_entry_save.sv ----
`timescale 1ns/1ns
`default_nettype none

module smm_entry_save
    import smm_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    // Pins
    input wire logic mgmt_irq_pin_n,
    input wire logic addr_bit20_mask_pin_n,
    // Configuration
    input wire logic [7:0] config_register_one,
    input wire logic [31:0] range_three_base,
    input wire logic [3:0] range_three_size,
    input wire logic range_three_write,
    // Interrupt arbitration
    input wire logic instr_boundary,
    input wire logic nmi_req,
    input wire logic intr_req,
    output logic take_mgmt,
    output logic take_nmi,
    output logic take_intr,
    // Processor state to save
    input wire logic [31:0] debug_control_register,
    input wire logic [31:0] processor_flags,
    input wire logic [31:0] control_register_zero,
    input wire logic [31:0] cur_ip,
    input wire logic [31:0] next_ip,
    input wire logic [15:0] cs_selector,
    input wire logic [63:0] cs_descriptor,
    input wire logic [1:0] privilege_level,
    input wire logic halted,
    input wire logic cs_writable,
    input wire logic internal_req,
    // Trapped port access
    input wire logic io_trap,
    input wire logic io_rep,
    input wire logic io_write,
    input wire logic [1:0] io_width,
    input wire logic [15:0] io_port,
    input wire logic [31:0] io_data,
    input wire logic [31:0] string_index,
    // Instruction requests
    input wire logic instr_valid,
    input wire logic [7:0] instr_opcode,
    input wire logic [2:0] instr_sreg,
    input wire logic [31:0] instr_operand,
    output logic instr_ready,
    output logic instr_done,
    output logic instr_fault,
    output logic [31:0] instr_result,
    output logic seg_go,
    output logic [7:0] seg_op,
    output logic [2:0] seg_reg,
    // Header memory port
    output logic mem_req,
    output logic mem_we,
    output logic [31:0] mem_addr,
    output logic [31:0] mem_wdata,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Mode control
    output logic management_mode,
    output logic enter_pulse,
    output logic [31:0] fetch_addr,
    output logic [31:0] cs_base,
    output logic [31:0] cs_limit,
    output logic resume_pulse,
    output logic restore_valid,
    output logic [3:0] restore_index,
    output logic [31:0] restore_data,
    // Address bit 20
    input wire logic region_access,
    input wire logic core_a20,
    output logic a20_out,
    // Header pointer view
    output logic [31:0] header_pointer
);

    // ********************************************************
    // Declarations
    // ********************************************************
    smm_state_t cur_ff;
    smm_state_t nxt_ff;
    smm_pin_if pin_bus ();
    logic irq_level;
    logic mask_level;
    logic region_on;
    logic [32:0] region_bytes;
    logic [31:0] top_of_region;
    logic priv_ok;
    logic entry_ok;
    logic [15:0] io_size_code;

    // Width code to header size field
    function automatic logic [15:0] width_code(input logic [1:0] w);
        unique case (w)
            2'h0: width_code = IO_SIZE_BYTE;
            2'h1: width_code = IO_SIZE_WORD;
            default: width_code = IO_SIZE_DWORD;
        endcase
    endfunction

    // Byte address of a header word
    function automatic logic [31:0] word_addr(input logic [31:0] p, input logic [3:0] k);
        word_addr = (p & HPTR_ADDR_MASK) - {26'h0, k + 4'h1, 2'h0};
    endfunction

    // ********************************************************
    // Pin synchroniser
    // ********************************************************
    assign pin_bus.raw = {addr_bit20_mask_pin_n, mgmt_irq_pin_n};
    assign irq_level = pin_bus.stable[0];
    assign mask_level = pin_bus.stable[1];

    smm_pin_sync u_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .clk_en(clk_en),
        .pins(pin_bus)
    );

    // ********************************************************
    // Region decode and enabling conditions
    // ********************************************************
    always_comb begin
        region_on = config_register_one[CFG1_REGION_EN_BIT] && (range_three_size != 4'h0);
        region_bytes = 33'h1 << (range_three_size + REGION_SHIFT);
        top_of_region = range_three_base + region_bytes[31:0];
        entry_ok = region_on && config_register_one[CFG1_USE_BIT];
        priv_ok = entry_ok && (privilege_level == 2'h0) && cur_ff.in_mode;
        io_size_code = width_code(io_width);
    end

    // Header word contents for the save walk
    function automatic logic [31:0] save_word(input logic [3:0] k, input logic sw);
        logic [31:0] w;
        w = 32'h0;
        unique case (k)
            HW_DEBUG: w = debug_control_register;
            HW_FLAGS: w = processor_flags;
            HW_CTRL0: w = control_register_zero;
            HW_CUR_IP: w = cur_ip;
            HW_NEXT_IP: w = (io_trap && io_rep) ? cur_ip : next_ip;
            HW_CS_SEL: begin
                w[15:0] = cs_selector;
                w[HB_PRIV_LO +: 2] = privilege_level;
                w[HB_INTERNAL] = internal_req;
                w[HB_HALTED] = halted;
                w[HB_SOFTWARE] = sw;
                w[HB_REP] = io_rep;
                w[HB_IO_WRITE] = io_write;
                w[HB_CS_WRITABLE] = cs_writable;
            end
            HW_DESC_LO: w = cs_descriptor[31:0];
            HW_DESC_HI: w = cs_descriptor[63:32];
            HW_IO_PORT: w = {io_port, io_size_code};
            HW_IO_DATA: w = io_data;
            HW_STR_IDX: w = string_index;
            default: w = 32'h0;
        endcase
        save_word = w;
    endfunction

    // ********************************************************
    // Arbitration: management request outranks everything else
    // ********************************************************
    always_comb begin
        take_mgmt = instr_boundary && cur_ff.pend && !cur_ff.in_mode
            && (cur_ff.st == SMM_IDLE) && entry_ok;
        take_nmi = instr_boundary && nmi_req && !take_mgmt;
        take_intr = instr_boundary && intr_req && !nmi_req && !take_mgmt;
        instr_ready = (cur_ff.st == SMM_IDLE) && !take_mgmt;
    end

    // ********************************************************
    // Sequencer next state
    // ********************************************************
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.pin_prev = irq_level;
        nxt_ff.done = 1'b0;
        nxt_ff.fault = 1'b0;
        nxt_ff.enter = 1'b0;
        nxt_ff.resumed = 1'b0;
        nxt_ff.rst_valid = 1'b0;
        nxt_ff.seg_go = 1'b0;

        // A write to range three clears the pointer valid bit
        if (range_three_write) begin
            nxt_ff.hptr[HPTR_VALID_BIT] = 1'b0;
        end

        unique case (cur_ff.st)
            SMM_IDLE: begin
                if (take_mgmt || (instr_valid && instr_ready && instr_opcode == OP_SW_ENTRY
                    && entry_ok && !cur_ff.in_mode)) begin
                    // Entry: fix the pointer first, then walk the header
                    nxt_ff.sw_entry = !take_mgmt;
                    if (take_mgmt) begin
                        nxt_ff.pend = 1'b0;
                    end else begin
                        nxt_ff.done = 1'b1;
                    end
                    if (!cur_ff.hptr[HPTR_VALID_BIT] || range_three_write) begin
                        nxt_ff.hptr = (top_of_region & HPTR_ADDR_MASK) | 32'h1;
                    end
                    nxt_ff.st = SMM_SAVE;
                    nxt_ff.idx = HW_DEBUG;
                end else if (instr_valid && instr_ready) begin
                    nxt_ff.done = 1'b1;
                    unique case (instr_opcode)
                        OP_SAVE_SEG, OP_REST_SEG, OP_SAVE_LDT, OP_REST_LDT,
                        OP_SAVE_TSK, OP_REST_TSK: begin
                            if (!priv_ok || ((instr_opcode == OP_SAVE_SEG
                                || instr_opcode == OP_REST_SEG)
                                && (instr_sreg == SREG_CS || instr_sreg > SREG_LAST))) begin
                                nxt_ff.fault = 1'b1;
                            end else begin
                                nxt_ff.seg_go = 1'b1;
                                nxt_ff.seg_op = instr_opcode;
                                nxt_ff.seg_reg = instr_sreg;
                            end
                        end
                        OP_RD_HPTR: begin
                            if (!priv_ok) begin
                                nxt_ff.fault = 1'b1;
                            end else begin
                                nxt_ff.result = cur_ff.hptr & ~32'h2;
                            end
                        end
                        OP_WR_HPTR: begin
                            if (!priv_ok) begin
                                nxt_ff.fault = 1'b1;
                            end else begin
                                nxt_ff.hptr = instr_operand & ~32'h2;
                            end
                        end
                        OP_RESUME: begin
                            if (!priv_ok) begin
                                nxt_ff.fault = 1'b1;
                            end else begin
                                nxt_ff.done = 1'b0;
                                nxt_ff.st = SMM_REST;
                                nxt_ff.idx = HW_DEBUG;
                            end
                        end
                        default: begin
                            nxt_ff.fault = 1'b1;
                        end
                    endcase
                end
            end
            SMM_SAVE: begin
                // One header word per memory handshake
                if (!cur_ff.mem_req) begin
                    nxt_ff.mem_req = 1'b1;
                    nxt_ff.mem_we = 1'b1;
                    nxt_ff.mem_addr = word_addr(cur_ff.hptr, cur_ff.idx);
                    nxt_ff.mem_wdata = save_word(cur_ff.idx, cur_ff.sw_entry);
                end else if (mem_ack) begin
                    nxt_ff.mem_req = 1'b0;
                    nxt_ff.mem_we = 1'b0;
                    if (cur_ff.idx == HW_LAST) begin
                        nxt_ff.st = SMM_IDLE;
                        nxt_ff.in_mode = 1'b1;
                        nxt_ff.enter = 1'b1;
                    end else begin
                        nxt_ff.idx = cur_ff.idx + 4'h1;
                    end
                end
            end
            SMM_REST: begin
                // Read back control words only; port fields stay in memory
                if (!cur_ff.mem_req) begin
                    nxt_ff.mem_req = 1'b1;
                    nxt_ff.mem_addr = word_addr(cur_ff.hptr, cur_ff.idx);
                end else if (mem_ack) begin
                    nxt_ff.mem_req = 1'b0;
                    nxt_ff.rst_valid = 1'b1;
                    nxt_ff.rst_idx = cur_ff.idx;
                    nxt_ff.rst_data = mem_rdata;
                    if (cur_ff.idx == HW_DESC_HI) begin
                        nxt_ff.st = SMM_IDLE;
                        nxt_ff.in_mode = 1'b0;
                        nxt_ff.resumed = 1'b1;
                        nxt_ff.done = 1'b1;
                    end else if (cur_ff.idx == HW_CTRL0) begin
                        nxt_ff.idx = HW_NEXT_IP;
                    end else begin
                        nxt_ff.idx = cur_ff.idx + 4'h1;
                    end
                end
            end
            default: begin
                nxt_ff.st = SMM_IDLE;
            end
        endcase

        // A new edge wins over the consume in the same cycle
        if (cur_ff.pin_prev && !irq_level) begin
            nxt_ff.pend = 1'b1;
        end
    end

    // ********************************************************
    // State register
    // ********************************************************
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '0;
            cur_ff.st <= SMM_IDLE;
            cur_ff.hptr <= HPTR_RESET;
            cur_ff.pin_prev <= 1'b1;
        end else if (clk_en) begin
            cur_ff <= nxt_ff;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign instr_done = cur_ff.done;
    assign instr_fault = cur_ff.fault;
    assign instr_result = cur_ff.result;
    assign seg_go = cur_ff.seg_go;
    assign seg_op = cur_ff.seg_op;
    assign seg_reg = cur_ff.seg_reg;
    assign mem_req = cur_ff.mem_req;
    assign mem_we = cur_ff.mem_we;
    assign mem_addr = cur_ff.mem_addr;
    assign mem_wdata = cur_ff.mem_wdata;
    assign management_mode = cur_ff.in_mode;
    assign enter_pulse = cur_ff.enter;
    assign fetch_addr = range_three_base;
    assign cs_base = range_three_base;
    assign cs_limit = CS_LIMIT_4G;
    assign resume_pulse = cur_ff.resumed;
    assign restore_valid = cur_ff.rst_valid;
    assign restore_index = cur_ff.rst_idx;
    assign restore_data = cur_ff.rst_data;
    assign header_pointer = cur_ff.hptr & ~32'h2;
    // Mask applies only outside region accesses
    assign a20_out = core_a20 && (region_access || mask_level);

endmodule

`default_nettype wire

// ---- rtl/smm_pin_sync.sv ----
`timescale 1ns/1ns
`default_nettype none

module smm_pin_sync
    import smm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic clk_en,
    // Pin levels
    smm_pin_if.sync pins
);

    smm_sync_t cur_ff;
    smm_sync_t nxt_ff;

    // Three stages; a level counts once stages two and three agree
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.s1 = pins.raw;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
        for (int i = 0; i < 2; i++) begin
            if (cur_ff.s2[i] == cur_ff.s3[i]) begin
                nxt_ff.stable[i] = cur_ff.s3[i];
            end
        end
    end

    // Inactive pins idle high
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, stable: 2'h3};
        end else if (clk_en) begin
            cur_ff <= nxt_ff;
        end
    end

    assign pins.stable = cur_ff.stable;

endmodule

`default_nettype wire

// ---- test/smm_chip_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module smm_chip_model (
    // Clock and controls
    input wire logic clk_sys,
    input wire logic fire,
    input wire logic slow,
    // Pin and header memory
    output logic mgmt_irq_pin_n,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [logic [31:0]];
    logic [1:0] wait_ff = 2'h0;
    initial {mgmt_irq_pin_n, mem_ack, mem_rdata} = {2'h2, 32'h00000000};
    // Pin follows the trigger; memory answers after two or four cycles
    always @(posedge clk_sys) begin
        mgmt_irq_pin_n <= !fire;
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        wait_ff <= (mem_req && !mem_ack) ? wait_ff + 2'h1 : 2'h0;
        if (mem_req && !mem_ack && wait_ff == {slow, 1'b1}) begin
            mem_ack <= 1'b1;
            if (mem_we) mem[mem_addr] = mem_wdata;
            else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 32'h00000000;
        end
    end
endmodule
`default_nettype wire

// ---- test/smm_entry_save_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
module smm_entry_save_monitor
    import smm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Watched outputs and their causes
    input wire logic take_mgmt,
    input wire logic take_nmi,
    input wire logic take_intr,
    input wire logic range_three_write,
    input wire logic instr_valid,
    input wire logic instr_ready,
    input wire logic [7:0] instr_opcode,
    input wire logic [2:0] instr_sreg,
    input wire logic instr_fault,
    input wire logic mem_req,
    input wire logic mem_ack,
    input wire logic [31:0] mem_addr,
    input wire logic management_mode,
    input wire logic enter_pulse,
    input wire logic restore_valid,
    input wire logic [3:0] restore_index,
    input wire logic [31:0] cs_limit,
    input wire logic [31:0] header_pointer
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    // Accepted instruction
    sequence take_op;
        instr_valid && instr_ready;
    endsequence
    mgmt_first_a: assert property (take_mgmt |-> !take_nmi && !take_intr)
        else $error("grant not exclusive");
    cs_limit_a: assert property (cs_limit == CS_LIMIT_4G) else $error("limit");
    hptr_bit1_a: assert property (header_pointer[1] == 1'b0) else $error("bit one");
    valid_clear_a: assert property (range_three_write && !take_mgmt && !instr_valid
        |=> !header_pointer[HPTR_VALID_BIT]) else $error("valid kept");
    mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("memory request dropped");
    cs_restore_a: assert property (take_op ##0 instr_opcode == OP_REST_SEG
        && instr_sreg == SREG_CS |=> instr_fault) else $error("no fault");
    gate_fault_a: assert property (take_op ##0 !management_mode
        && instr_opcode == OP_RD_HPTR |=> instr_fault) else $error("no fault");
    enter_valid_a: assert property (enter_pulse |-> header_pointer[0] ##1 management_mode)
        else $error("entry incomplete");
    io_kept_a: assert property (restore_valid |-> restore_index != HW_IO_PORT
        && restore_index != HW_IO_DATA) else $error("port word restored");
endmodule
bind smm_entry_save smm_entry_save_monitor u_smm_entry_save_monitor (.*);
`default_nettype wire

// ---- test/smm_entry_save_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module smm_entry_save_tb;
    import smm_pkg::*;
    logic clk_sys = 0, resetn = 0, clk_en = 1, addr_bit20_mask_pin_n = 0, fire = 0, slow = 0;
    logic instr_boundary = 1, nmi_req = 1, intr_req = 1, halted = 1, cs_writable = 0;
    logic internal_req = 0, io_trap = 1, io_rep = 1, io_write = 1, instr_valid = 0;
    logic region_access = 1, core_a20 = 1, range_three_write = 0, take_mgmt, take_nmi, take_intr;
    logic instr_ready, instr_done, instr_fault, seg_go, mem_req, mem_we, mem_ack, a20_out;
    logic management_mode, enter_pulse, resume_pulse, restore_valid, mgmt_irq_pin_n;
    logic [7:0] seg_op, instr_opcode = 8'h00, config_register_one = 8'h82;
    logic [31:0] range_three_base = 32'h00010000, debug_control_register = 32'h00000400;
    logic [31:0] processor_flags = 32'h00000002, control_register_zero = 32'h00000010;
    logic [31:0] cur_ip = 32'h00001234, next_ip = 32'h00001236, io_data = 32'h0000A5A5;
    logic [31:0] string_index = 32'h00000077, instr_operand = 32'h00000000, instr_result;
    logic [31:0] mem_addr, mem_wdata, mem_rdata, fetch_addr, cs_base, cs_limit, restore_data;
    logic [31:0] header_pointer;
    logic [63:0] cs_descriptor = 64'h123456789ABCDEF0;
    logic [15:0] cs_selector = 16'hF000, io_port = 16'h00B2;
    logic [3:0] restore_index, range_three_size = 4'h1;
    logic [2:0] seg_reg, instr_sreg = 3'h1;
    logic [1:0] privilege_level = 2'h0, io_width = 2'h1;
    int errors = 0, comparisons = 0;
    smm_entry_save u_smm_entry_save (.*);
    smm_chip_model u_smm_chip_model (.*);
    // 10 MHz clock
    always #50 clk_sys = ~clk_sys;
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wait_for(ref logic flag);
        for (int n = 0; flag !== 1'b1; n++) begin
            if (n > 500) check("wait", 32'h1, 32'h0);
            if (n > 500) close_out();
            @(posedge clk_sys) #1;
        end
    endtask
    task automatic issue(logic [7:0] op, logic fault);
        @(posedge clk_sys);
        instr_opcode <= op;
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        instr_valid <= 1'b0;
        #1 check("fault", {31'h0, fault}, {31'h0, instr_fault});
        check("done", {31'h0, op != OP_RESUME}, {31'h0, instr_done});
    endtask
    // Pin request: header save and entry state
    task automatic hw_entry();
        fire <= 1'b1;
        repeat (4) @(posedge clk_sys);
        fire <= 1'b0;
        wait_for(enter_pulse);
        check("pointer", 32'h00011001, header_pointer);
        check("fetch", range_three_base, fetch_addr);
        check("cs base", range_three_base, cs_base);
        check("next ip", 32'h00001234, u_smm_chip_model.mem[32'h00010FEC]);
        check("flags", 32'h0068F000, u_smm_chip_model.mem[32'h00010FE8]);
        check("port", 32'h00B20003, u_smm_chip_model.mem[32'h00010FDC]);
        check("desc hi", 32'h12345678, u_smm_chip_model.mem[32'h00010FE0]);
        @(posedge clk_sys) region_access <= 1'b0;
        #1 check("a20 masked", 32'h0, {31'h0, a20_out});
        @(posedge clk_sys) region_access <= 1'b1;
    endtask
    // Instructions inside the service routine
    task automatic in_mode_ops();
        issue(OP_REST_SEG, 1'b1);
        issue(OP_SAVE_LDT, 1'b0);
        check("seg op", {24'h0, OP_SAVE_LDT}, {24'h0, seg_op});
        issue(OP_RD_HPTR, 1'b0);
        check("result", 32'h00011001, instr_result);
        @(posedge clk_sys) instr_operand <= 32'h00022003;
        issue(OP_WR_HPTR, 1'b0);
        check("written", 32'h00022001, header_pointer);
        @(posedge clk_sys) instr_operand <= 32'h00011001;
        issue(OP_WR_HPTR, 1'b0);
        check("rewritten", 32'h00011001, header_pointer);
    endtask
    // Resume reads control words back, then pointer is invalidated
    task automatic resume_out();
        slow <= 1'b1;
        issue(OP_RESUME, 1'b0);
        wait_for(resume_pulse);
        check("resume done", 32'h1, {31'h0, instr_done});
        check("mode", 32'h0, {31'h0, management_mode});
        check("last index", {28'h0, HW_DESC_HI}, {28'h0, restore_index});
        check("restored", 32'h12345678, restore_data);
        @(posedge clk_sys) range_three_write <= 1'b1;
        @(posedge clk_sys) range_three_write <= 1'b0;
        #1 check("valid", 32'h0, {31'h0, header_pointer[0]});
    endtask
    // Software entry recomputes the invalid pointer
    task automatic sw_entry();
        issue(OP_SW_ENTRY, 1'b0);
        wait_for(enter_pulse);
        check("sw pointer", 32'h00011001, header_pointer);
        check("sw flags", 32'h0078F000, u_smm_chip_model.mem[32'h00010FE8]);
    endtask
    // Main sequence
    initial begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        #1 check("pointer", 32'h00000000, header_pointer);
        check("a20", 32'h1, {31'h0, a20_out});
        check("nmi", 32'h1, {31'h0, take_nmi});
        check("intr", 32'h0, {31'h0, take_intr});
        issue(OP_RD_HPTR, 1'b1);
        hw_entry();
        in_mode_ops();
        resume_out();
        sw_entry();
        close_out();
    end
endmodule
`default_nettype wire
